//--- inc/sls_defines.svh
// constants for the single load/store unit
// assumes inclusion by bare name from the unit and its package users
`ifndef SLS_DEFINES_SVH
`define SLS_DEFINES_SVH

// apb register byte offsets
`define SLS_OFF_CTRL 8'h00
`define SLS_OFF_STAT 8'h04
`define SLS_OFF_COUNT 8'h08
`define SLS_OFF_LAST 8'h0c

// field positions
`define SLS_CTRL_EN 0
`define SLS_STAT_BUSY 0
`define SLS_STAT_ILL 1

// reset values
`define SLS_CTRL_EN_RST 1'b1
`define SLS_COUNT_RST 32'h0

// datapath constants
`define SLS_SH_FULL 6'h20
`define SLS_LANE_LSB 3
`define SLS_BYTE_MSB 7

`endif

//--- inc/sls_pkg.sv
// types for the single load/store unit
// assumes sls_defines.svh for numeric constants
package sls_pkg;

   typedef enum logic [1:0] {
      SL_IDLE = 2'b01,
      SL_MEM = 2'b10
   } sls_fsm_e;

   typedef enum logic [1:0] {
      SH_LSL = 2'h0,
      SH_LSR = 2'h1,
      SH_ASR = 2'h2,
      SH_ROR = 2'h3
   } sls_sh_e;

   // one transfer request from the core
   typedef struct packed {
      logic load;
      logic is_byte;
      logic user_translate_pin;
      logic pre;
      logic up;
      logic wback;
      logic imm_sel;
      logic [11:0] imm;
      sls_sh_e sh_type;
      logic [4:0] sh_amt;
      logic carry_in;
      logic [3:0] rd_idx;
      logic [3:0] base_idx;
      logic [31:0] base;
      logic [31:0] index;
      logic [31:0] store_data;
   } sls_req_s;

   // memory side request
   typedef struct packed {
      logic req;
      logic write;
      logic is_byte;
      logic user_translate_pin;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sls_mem_s;

   // register file write-back
   typedef struct packed {
      logic rd_we;
      logic [3:0] rd_idx;
      logic [31:0] rd_data;
      logic base_we;
      logic [3:0] base_idx;
      logic [31:0] base_data;
   } sls_wb_s;

   typedef struct packed {
      sls_fsm_e fsm;
      logic ready;
      sls_mem_s mem;
      sls_wb_s wb;
      logic done;
      logic err;
      logic pre;
      logic wback;
      logic load;
      logic [1:0] lane;
      logic [31:0] wb_val;
      logic ctrl_en;
      logic ill;
      logic [31:0] count;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sls_st_s;

endpackage : sls_pkg

//--- hw/sls_unit.sv
// single data transfer unit: one word or byte between core and memory
// assumes a memory system that answers each request with one ack pulse,
// and a core that presents requests with valid/ready
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "sls_defines.svh"

module sls_unit
   import sls_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire sls_req_s REQ,
   output sls_mem_s MEM,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_RDATA,
   output sls_wb_s WB,
   output logic DONE,
   output logic ERR
);

   sls_st_s st;
   sls_st_s next_st;
   logic [31:0] shifted;
   logic [31:0] offset;
   logic [31:0] off_addr;
   logic take;
   logic accept;
   logic illegal;
   logic mem_done;
   logic [31:0] rd_val;
   logic hit;

   // register index through the barrel shifter, immediate amount only
   function automatic logic [31:0] sls_shift(
      input logic [31:0] v,
      input sls_sh_e t,
      input logic [4:0] a,
      input logic c
   );
      logic [31:0] r;
      r = v;
      case (t)
         SH_LSL: begin
            r = v << a;
         end
         SH_LSR: begin
            // amount 0 encodes a full 32-bit shift
            r = (a == 5'h0) ? 32'h0 : v >> a;
         end
         SH_ASR: begin
            r = (a == 5'h0) ? {32{v[31]}} : 32'($signed(v) >>> a);
         end
         default: begin
            // amount 0 is rotate through carry
            if (a == 5'h0) begin
               r = {c, v[31:1]};
            end else begin
               r = (v >> a) | (v << (`SLS_SH_FULL - {1'b0, a}));
            end
         end
      endcase
      return r;
   endfunction : sls_shift

   function automatic logic [31:0] sls_apply(
      input logic [31:0] b,
      input logic [31:0] o,
      input logic up
   );
      return up ? b + o : b - o;
   endfunction : sls_apply

   // byte lane pick, little-endian within the returned word
   function automatic logic [7:0] sls_lane(
      input logic [31:0] w,
      input logic [1:0] l
   );
      return 8'(w >> ({l, 3'h0}));
   endfunction : sls_lane

   always_comb begin
      shifted = sls_shift(REQ.index, REQ.sh_type, REQ.sh_amt, REQ.carry_in);
      if (REQ.imm_sel) begin
         offset = 32'(REQ.imm);
      end else begin
         offset = shifted;
      end
      off_addr = sls_apply(REQ.base, offset, REQ.up);
      take = CE && REQ_VALID && st.ready;
      illegal = REQ.user_translate_pin && REQ.pre;
      accept = take && !illegal;
      mem_done = CE && (st.fsm == SL_MEM) && MEM_ACK;
   end

   // apb read decode
   always_comb begin
      rd_val = 32'h0;
      hit = 1'b1;
      if (PADDR == `SLS_OFF_CTRL) begin
         rd_val[`SLS_CTRL_EN] = st.ctrl_en;
      end else if (PADDR == `SLS_OFF_STAT) begin
         rd_val[`SLS_STAT_BUSY] = (st.fsm != SL_IDLE);
         rd_val[`SLS_STAT_ILL] = st.ill;
      end else if (PADDR == `SLS_OFF_COUNT) begin
         rd_val = st.count;
      end else if (PADDR == `SLS_OFF_LAST) begin
         rd_val = st.mem.addr;
      end else begin
         hit = 1'b0;
      end
   end

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      next_st.err = 1'b0;
      next_st.wb.rd_we = 1'b0;
      next_st.wb.base_we = 1'b0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;

      // no wait state: answer registered from the setup cycle
      if (PSEL && !PENABLE) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !hit;
         next_st.prdata = rd_val;
      end
      if (PSEL && PENABLE && st.pready && PWRITE && !st.pslverr) begin
         if (PADDR == `SLS_OFF_CTRL) begin
            next_st.ctrl_en = PWDATA[`SLS_CTRL_EN];
         end else if (PADDR == `SLS_OFF_STAT) begin
            // clear first so a same-cycle set below wins
            if (PWDATA[`SLS_STAT_ILL]) begin
               next_st.ill = 1'b0;
            end
         end else if (PADDR == `SLS_OFF_COUNT) begin
            next_st.count = PWDATA;
         end
      end

      case (st.fsm)
         SL_IDLE: begin
            if (REQ_VALID && st.ready) begin
               if (illegal) begin
                  // refused: no memory access, no write-back
                  next_st.err = 1'b1;
                  next_st.ill = 1'b1;
               end else begin
                  next_st.fsm = SL_MEM;
                  next_st.mem.req = 1'b1;
                  next_st.mem.write = !REQ.load;
                  next_st.mem.is_byte = REQ.is_byte;
                  next_st.mem.user_translate_pin = REQ.user_translate_pin;
                  if (REQ.pre) begin
                     next_st.mem.addr = off_addr;
                  end else begin
                     next_st.mem.addr = REQ.base;
                  end
                  if (REQ.is_byte) begin
                     // byte copied to every lane, memory picks by address
                     next_st.mem.wdata = {4{REQ.store_data[`SLS_BYTE_MSB:0]}};
                  end else begin
                     next_st.mem.wdata = REQ.store_data;
                  end
                  next_st.lane = REQ.pre ? off_addr[1:0] : REQ.base[1:0];
                  next_st.wb_val = off_addr;
                  next_st.pre = REQ.pre;
                  next_st.wback = REQ.wback;
                  next_st.load = REQ.load;
                  next_st.wb.rd_idx = REQ.rd_idx;
                  next_st.wb.base_idx = REQ.base_idx;
               end
            end
         end
         SL_MEM: begin
            if (MEM_ACK) begin
               next_st.fsm = SL_IDLE;
               next_st.mem.req = 1'b0;
               next_st.mem.user_translate_pin = 1'b0;
               next_st.done = 1'b1;
               next_st.count = st.count + 32'h1;
               if (st.load) begin
                  next_st.wb.rd_we = 1'b1;
                  if (st.mem.is_byte) begin
                     next_st.wb.rd_data = 32'(sls_lane(MEM_RDATA, st.lane));
                  end else begin
                     // unaligned word loads are passed through untouched
                     next_st.wb.rd_data = MEM_RDATA;
                  end
               end
               if (!st.pre || st.wback) begin
                  next_st.wb.base_we = 1'b1;
                  next_st.wb.base_data = st.wb_val;
               end
            end
         end
         default: begin
            next_st.fsm = SL_IDLE;
         end
      endcase

      next_st.ready = (next_st.fsm == SL_IDLE) && next_st.ctrl_en;
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st <= '0;
         st.fsm <= SL_IDLE;
         st.ctrl_en <= `SLS_CTRL_EN_RST;
         st.count <= `SLS_COUNT_RST;
      end else if (CE) begin
         st <= next_st;
      end
   end

   assign PRDATA = st.prdata;
   assign PREADY = st.pready;
   assign PSLVERR = st.pslverr;
   assign REQ_READY = st.ready;
   assign MEM = st.mem;
   assign WB = st.wb;
   assign DONE = st.done;
   assign ERR = st.err;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   AST_MEM_DIR: assert property (accept |=> MEM.req && (MEM.write == !$past(REQ.load)))
      else $error("memory direction does not follow the operation");

   AST_SIZE: assert property (accept |=> MEM.is_byte == $past(REQ.is_byte))
      else $error("transfer size does not follow the byte qualifier");

   AST_BYTE_ZERO: assert property (WB.rd_we && MEM.is_byte |-> WB.rd_data[31:8] == 24'h0)
      else $error("byte load left upper bits set");

   AST_USER_TRANSLATE_PIN_HELD: assert property (MEM.req && MEM.user_translate_pin && !MEM_ACK |=> MEM.user_translate_pin)
      else $error("translate pin dropped during access");

   AST_ILLEGAL: assert property (take && illegal |=> ERR && !MEM.req && REQ_READY)
      else $error("translate with pre-index was not refused");

   AST_PRE_ADDR: assert property (accept && REQ.pre |=> MEM.addr == $past(off_addr))
      else $error("pre-indexed address wrong");

   AST_POST_ADDR: assert property (accept && !REQ.pre |=> MEM.addr == $past(REQ.base))
      else $error("post-indexed address is not the base");

   AST_POST_WB: assert property (mem_done && !st.pre |=> WB.base_we && DONE
      && WB.base_data == $past(st.wb_val))
      else $error("post-indexed write-back missing");

   AST_PRE_NOWB: assert property (mem_done && st.pre && !st.wback |=> DONE && !WB.base_we)
      else $error("pre-indexed base changed without write-back");

   AST_IMM_NEG: assert property (accept && REQ.imm_sel && !REQ.up && REQ.pre
      |=> MEM.addr == $past(REQ.base) - 32'($past(REQ.imm)))
      else $error("negative immediate offset wrong");

   AST_REG_LSL: assert property (accept && !REQ.imm_sel && REQ.sh_type == SH_LSL
      && REQ.up && REQ.pre
      |=> MEM.addr == $past(REQ.base) + ($past(REQ.index) << $past(REQ.sh_amt)))
      else $error("shifted register index wrong");

   AST_ZERO_IDX: assert property (accept && REQ.imm_sel && REQ.imm == 12'h0
      |=> MEM.addr == $past(REQ.base))
      else $error("zero index did not give the base");

   AST_WORD_LOAD: assert property (mem_done && st.load && !st.mem.is_byte
      |=> WB.rd_we && WB.rd_data == $past(MEM_RDATA))
      else $error("word load data wrong");

   AST_STORE_NO_RD: assert property (mem_done && !st.load |=> !WB.rd_we)
      else $error("store wrote a register");

   AST_STORE_WORD: assert property (accept && !REQ.load && !REQ.is_byte
      |=> MEM.wdata == $past(REQ.store_data))
      else $error("stored word differs from the register");

   AST_BYTE_STORE: assert property (accept && !REQ.load && REQ.is_byte
      |=> MEM.wdata == {4{$past(REQ.store_data[7:0])}})
      else $error("stored byte not on every lane");

   AST_BYTE_LANE: assert property (mem_done && st.load && st.mem.is_byte
      |=> WB.rd_we && WB.rd_data[7:0] == 8'($past(MEM_RDATA) >> {$past(MEM.addr[1:0]), 3'h0}))
      else $error("byte load took the wrong lane");

   AST_PRE_WB: assert property (mem_done && st.pre && st.wback
      |=> WB.base_we && WB.base_data == $past(MEM.addr))
      else $error("pre-indexed write-back is not the address");

   AST_USER_TRANSLATE_PIN_SET: assert property (accept |=> MEM.user_translate_pin == $past(REQ.user_translate_pin))
      else $error("translate pin does not follow the request");

   AST_USER_TRANSLATE_PIN_END: assert property (mem_done |=> !MEM.user_translate_pin)
      else $error("translate pin left active after the access");

   AST_IMM_POS: assert property (accept && REQ.imm_sel && REQ.up && REQ.pre
      |=> MEM.addr == $past(REQ.base) + 32'($past(REQ.imm)))
      else $error("positive immediate offset wrong");

   AST_RRX: assert property (accept && !REQ.imm_sel && REQ.sh_type == SH_ROR
      && REQ.sh_amt == 5'h0 && REQ.up && REQ.pre
      |=> MEM.addr == $past(REQ.base) + {$past(REQ.carry_in), $past(REQ.index[31:1])})
      else $error("rotate through carry index wrong");

   AST_REFUSE_QUIET: assert property (take && illegal
      |=> !WB.rd_we && !WB.base_we && !DONE)
      else $error("refused request still wrote back");

   COV_WORD_LOAD: cover property (mem_done && st.load && !st.mem.is_byte);
   COV_BYTE_STORE: cover property (mem_done && !st.load && st.mem.is_byte);
   COV_POST_USER_TRANSLATE_PIN: cover property (accept && REQ.user_translate_pin && !REQ.pre);
   COV_ILLEGAL: cover property (take && illegal);
   COV_REG_ROR: cover property (accept && !REQ.imm_sel && REQ.sh_type == SH_ROR);

endmodule : sls_unit

//--- sim/sls_mem_model.sv
// memory system stand-in: sixteen words, ack after a set delay
// assumes the unit holds its request until the ack edge
`timescale 1ns/100ps
module sls_mem_model
   import sls_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire sls_mem_s MEM,
   input wire logic [3:0] DLY,
   output logic MEM_ACK,
   output logic [31:0] MEM_RDATA
);
   logic [31:0] ram [0:15];
   logic [3:0] cnt = 4'h0;
   logic [31:0] last = 32'h0;
   logic [4:0] sh;
   initial for (int i = 0; i < 16; i++) ram[i] = 32'hffffffff;
   assign sh = {MEM.addr[1:0], 3'b000};
   assign MEM_ACK = MEM.req && (cnt == DLY);
   // idle data bus toggles so stale data never looks valid
   assign MEM_RDATA = MEM_ACK ? ram[MEM.addr[5:2]] : ~last;
   always @(posedge CLK) begin
      cnt <= (MEM.req && !MEM_ACK && !SYS_RST) ? cnt + 4'h1 : 4'h0;
      last <= MEM_RDATA;
      if (MEM_ACK && MEM.write && MEM.is_byte) begin
         ram[MEM.addr[5:2]][sh +: 8] <= MEM.wdata[sh +: 8];
      end else if (MEM_ACK && MEM.write) begin
         ram[MEM.addr[5:2]] <= MEM.wdata;
      end
   end
endmodule : sls_mem_model

//--- sim/tb.sv
// testbench: apb register checks and single transfers through the unit
// assumes sls_mem_model as the memory side
`timescale 1ns/100ps
`include "sls_defines.svh"
module tb
   import sls_pkg::*;
;
   logic CLK, SYS_RST = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q, PRDATA, MEM_RDATA;
   logic PREADY, PSLVERR, REQ_READY, MEM_ACK, DONE, ERR, e, req_valid = 1'b0;
   logic [3:0] dly = 4'h0;
   sls_req_s req = '0;
   sls_mem_s mem_o;
   sls_wb_s wb;
   int err_count = 0, n_tests = 0;
   sls_unit uut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .REQ_VALID(req_valid), .REQ_READY(REQ_READY), .REQ(req),
      .MEM(mem_o), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .WB(wb), .DONE(DONE), .ERR(ERR));
   sls_mem_model mm (.CLK(CLK), .SYS_RST(SYS_RST), .MEM(mem_o), .DLY(dly),
      .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
   task automatic finish_test;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge CLK);
      penable <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      q = PRDATA; e = PSLVERR;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   // f = load, byte, user_translate_pin, pre, up, wback, imm_sel; sh = type, amount
   task automatic xfer(input logic [6:0] f, input logic [11:0] imm, input logic [6:0] sh,
         input logic [31:0] b, input logic [31:0] ix, input logic [31:0] sd,
         input logic [31:0] ea, input logic [31:0] ed, input logic [31:0] eb);
      sls_req_s r;
      r = '0;
      {r.load, r.is_byte, r.user_translate_pin, r.pre, r.up, r.wback, r.imm_sel} = f;
      r.imm = imm; {r.sh_type, r.sh_amt} = sh; r.rd_idx = 4'h3; r.base_idx = 4'h5;
      r.base = b; r.index = ix; r.store_data = sd;
      @(posedge CLK);
      req <= r; req_valid <= 1'b1;
      do @(posedge CLK); while (REQ_READY !== 1'b1);
      req_valid <= 1'b0;
      if (r.user_translate_pin && r.pre) begin
         @(posedge CLK);
         chk("err", ERR, 1);
         chk("mreq", mem_o.req, 0);
         return;
      end
      do @(posedge CLK); while (mem_o.req !== 1'b1);
      chk("addr", mem_o.addr, ea);
      chk("wr", mem_o.write, !r.load);
      chk("byte", mem_o.is_byte, r.is_byte);
      chk("user_translate_pin", mem_o.user_translate_pin, r.user_translate_pin);
      if (!r.load) chk("wdata", mem_o.wdata, r.is_byte ? {4{sd[7:0]}} : sd);
      do @(posedge CLK); while (DONE !== 1'b1);
      chk("rdwe", wb.rd_we, r.load);
      chk("rdidx", wb.rd_idx, 32'h3);
      chk("trdrop", mem_o.user_translate_pin, 32'h0);
      if (r.load) chk("rdata", wb.rd_data, ed);
      chk("bwe", wb.base_we, !r.pre || r.wback);
      if (!r.pre || r.wback) chk("bdata", wb.base_data, eb);
      if (!r.pre || r.wback) chk("bidx", wb.base_idx, 32'h5);
   endtask : xfer
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   initial begin
      repeat (3000) @(posedge CLK);
      err_count++;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge CLK);
      SYS_RST <= 1'b0;
      apb(1'b0, `SLS_OFF_CTRL, 32'h0);
      chk("ctrl", q, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk("slverr", {q[30:0], e}, 32'h1);
      apb(1'b1, `SLS_OFF_COUNT, 32'h5);
      // word bases aligned, program counter never the base
      xfer(7'b0001111, 12'h008, 7'h0, 32'h10, 32'h0, 32'ha1b2c3d4, 32'h18, 32'h0, 32'h18);
      dly <= 4'h3;
      xfer(7'b0110000, 12'h0, {SH_LSL, 5'd2}, 32'h21, 32'h1, 32'h5a, 32'h21, 32'h0, 32'h1d);
      dly <= 4'h0;
      xfer(7'b1001001, 12'h0, 7'h0, 32'h18, 32'h0, 32'h0, 32'h18, 32'ha1b2c3d4, 32'h0);
      xfer(7'b1101001, 12'hfff, 7'h0, 32'h1020, 32'h0, 32'h0, 32'h21, 32'h5a, 32'h0);
      xfer(7'b1001100, 12'h0, {SH_LSL, 5'd2}, 32'h10, 32'h2, 32'h0, 32'h18,
         32'ha1b2c3d4, 32'h0);
      xfer(7'b1000000, 12'h0, {SH_LSR, 5'd4}, 32'h18, 32'h80, 32'h0, 32'h18,
         32'ha1b2c3d4, 32'h10);
      xfer(7'b1001110, 12'h0, {SH_ROR, 5'd0}, 32'h0, 32'h10, 32'h0, 32'h8,
         32'hffffffff, 32'h8);
      xfer(7'b1001000, 12'h0, {SH_ROR, 5'd4}, 32'h40000010, 32'h4, 32'h0, 32'h10,
         32'hffffffff, 32'h0);
      xfer(7'b1000100, 12'h0, {SH_ASR, 5'd0}, 32'h20, 32'h80000000, 32'h0, 32'h20,
         32'hffff5aff, 32'h1f);
      xfer(7'b1011100, 12'h4, 7'h0, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
      apb(1'b0, `SLS_OFF_STAT, 32'h0);
      chk("stat", q, 32'h2);
      apb(1'b0, `SLS_OFF_COUNT, 32'h0);
      chk("count", q, 32'he);
      apb(1'b0, `SLS_OFF_LAST, 32'h0);
      chk("last", q, 32'h20);
      apb(1'b1, `SLS_OFF_STAT, 32'h2);
      apb(1'b0, `SLS_OFF_STAT, 32'h0);
      chk("stat_clr", q, 32'h0);
      apb(1'b1, `SLS_OFF_CTRL, 32'h0);
      @(posedge CLK);
      chk("ready_off", REQ_READY, 32'h0);
      finish_test;
   end
endmodule : tb
